// file: core/cpt_pkg.sv
// constants, field layouts and types of the compact timer
package cpt_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] CPT_OFS_COUNT_LOW  = 8'h00;
  localparam logic [7:0] CPT_OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] CPT_OFS_CMPA_LOW   = 8'h08;
  localparam logic [7:0] CPT_OFS_CMPA_HIGH  = 8'h0C;
  localparam logic [7:0] CPT_OFS_CONTROL_0  = 8'h10;
  localparam logic [7:0] CPT_OFS_CONTROL_1  = 8'h14;
  localparam logic [7:0] CPT_OFS_STATUS     = 8'h18;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int         CPT_CNT_W        = 10;
  localparam int         CPT_PER_W        = 3;
  localparam int         CPT_C0_RUN_BIT   = 0;
  localparam int         CPT_C0_PER_LSB   = 4;
  localparam int         CPT_ST_FLAG_A    = 0;
  localparam int         CPT_ST_FLAG_P    = 1;
  localparam logic [9:0] CPT_COUNT_RESET  = 10'h000;
  localparam logic [9:0] CPT_CMPA_RESET   = 10'h000;
  localparam logic [9:0] CPT_COUNT_MAX    = 10'h3FF;
  localparam logic [2:0] CPT_PER_RESET    = 3'h0;
  localparam logic [7:0] CPT_CTRL1_RESET  = 8'h00;
  localparam logic [10:0] CPT_FULL_SPAN   = 11'h400;

  // ----------------------------------------
  // modes and pin actions
  // ----------------------------------------
  typedef enum logic [1:0] {
    CPT_MODE_COMPARE = 2'h0,
    CPT_MODE_UNUSED  = 2'h1,
    CPT_MODE_PWM     = 2'h2,
    CPT_MODE_TIMER   = 2'h3
  } cpt_mode_t;

  typedef enum logic [1:0] {
    CPT_ACT_NONE   = 2'h0,
    CPT_ACT_LOW    = 2'h1,
    CPT_ACT_HIGH   = 2'h2,
    CPT_ACT_TOGGLE = 2'h3
  } cpt_action_t;

  typedef struct packed {
    cpt_mode_t   mode;
    cpt_action_t action;
    logic        initial_output;
    logic        output_polarity;
    logic        period_duty_swap;
    logic        clear_select;
  } cpt_ctrl1_t;

endpackage : cpt_pkg

// file: core/cpt_timer.sv
// compact timer: 10-bit counter, comparators A and P, APB register slave
`timescale 1ns/1ps
`default_nettype none

module cpt_timer
  import cpt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RESET_N_IN,
  input  wire logic              PSEL_IN,
  input  wire logic              PENABLE_IN,
  input  wire logic              PWRITE_IN,
  input  wire logic [ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]       PWDATA_IN,
  output var  logic [31:0]       PRDATA_OUT,
  output var  logic              PREADY_OUT,
  output var  logic              PSLVERR_OUT,
  output var  logic              TIMER_PIN_OUT,
  output var  logic              TIMER_PIN_OE_OUT,
  output var  logic              FLAG_A_OUT,
  output var  logic              FLAG_P_OUT
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (ADDR_W < 5) begin : g_bad_addr
    $error("ADDR_W too narrow for the register map");
  end

  // the datapath below is written for a 10-bit counter and a 3-bit period
  if (CPT_CNT_W != 10) begin : g_bad_cnt_w
    $error("counter width must be 10 bits");
  end

  if (CPT_PER_W != 3) begin : g_bad_per_w
    $error("period field must be 3 bits");
  end

  // control and status fields must sit inside the byte that software sees
  if (CPT_C0_PER_LSB + CPT_PER_W > 8) begin : g_bad_per_pos
    $error("period field overruns control byte");
  end

  if (CPT_C0_RUN_BIT > 7) begin : g_bad_run_pos
    $error("run bit outside control byte");
  end

  if (CPT_ST_FLAG_A > 7 || CPT_ST_FLAG_P > 7) begin : g_bad_flag_pos
    $error("status flag outside status byte");
  end

  if (CPT_ST_FLAG_A == CPT_ST_FLAG_P) begin : g_same_flag_pos
    $error("status flags share one bit");
  end

  // every register takes one aligned word of the bus
  if (((CPT_OFS_COUNT_HIGH | CPT_OFS_CMPA_LOW | CPT_OFS_CMPA_HIGH | CPT_OFS_CONTROL_0 |
        CPT_OFS_CONTROL_1 | CPT_OFS_STATUS) & 8'h03) != 8'h00) begin : g_bad_align
    $error("register offsets must be word aligned");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [9:0] count;
  logic [9:0] compare_a_value;
  logic [2:0] period_value;
  logic       timer_run;
  logic       run_prev;
  cpt_ctrl1_t ctrl1;
  logic       compare_a_flag;
  logic       compare_p_flag;
  logic       pin_level;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire logic [7:0] addr8      = 8'(PADDR_IN);
  wire logic       setup_cyc  = PSEL_IN & ~PENABLE_IN;
  wire logic       access_cyc = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire logic       wr_cyc     = access_cyc & PWRITE_IN;

  wire logic hit_cnt_lo = (addr8 == CPT_OFS_COUNT_LOW);
  wire logic hit_cnt_hi = (addr8 == CPT_OFS_COUNT_HIGH);
  wire logic hit_cma_lo = (addr8 == CPT_OFS_CMPA_LOW);
  wire logic hit_cma_hi = (addr8 == CPT_OFS_CMPA_HIGH);
  wire logic hit_ctrl0  = (addr8 == CPT_OFS_CONTROL_0);
  wire logic hit_ctrl1  = (addr8 == CPT_OFS_CONTROL_1);
  wire logic hit_status = (addr8 == CPT_OFS_STATUS);

  // upper address bits beyond the map make the access unmapped
  wire logic upper_clear = (ADDR_W > 8) ? (PADDR_IN >> 8) == '0 : 1'b1;
  wire logic mapped = upper_clear & (hit_cnt_lo | hit_cnt_hi | hit_cma_lo | hit_cma_hi |
                                     hit_ctrl0 | hit_ctrl1 | hit_status);

  wire logic wr_cma_lo = wr_cyc & upper_clear & hit_cma_lo;
  wire logic wr_cma_hi = wr_cyc & upper_clear & hit_cma_hi;
  wire logic wr_ctrl0  = wr_cyc & upper_clear & hit_ctrl0;
  wire logic wr_ctrl1  = wr_cyc & upper_clear & hit_ctrl1;
  wire logic wr_status = wr_cyc & upper_clear & hit_status;

  // the two count bytes are not latched together; stopping the timer clears the count to zero
  logic [31:0] read_word;
  always_comb begin
    read_word = 32'h0000_0000;
    if (!upper_clear) begin
      read_word = 32'h0000_0000;
    end else if (hit_cnt_lo) begin
      read_word[7:0] = count[7:0];
    end else if (hit_cnt_hi) begin
      read_word[1:0] = count[9:8];
    end else if (hit_cma_lo) begin
      read_word[7:0] = compare_a_value[7:0];
    end else if (hit_cma_hi) begin
      read_word[1:0] = compare_a_value[9:8];
    end else if (hit_ctrl0) begin
      read_word[CPT_C0_RUN_BIT] = timer_run;
      read_word[CPT_C0_PER_LSB +: CPT_PER_W] = period_value;
    end else if (hit_ctrl1) begin
      read_word[7:0] = ctrl1;
    end else if (hit_status) begin
      read_word[CPT_ST_FLAG_A] = compare_a_flag;
      read_word[CPT_ST_FLAG_P] = compare_p_flag;
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire logic mode_cmp   = (ctrl1.mode == CPT_MODE_COMPARE);
  wire logic mode_pwm   = (ctrl1.mode == CPT_MODE_PWM);
  // mode 01 is undefined; it runs as timer/counter with the pin released
  wire logic mode_timer = ~(mode_cmp | mode_pwm);
  wire logic pin_used   = ~mode_timer;
  wire logic run_rise   = timer_run & ~run_prev;

  // ----------------------------------------
  // comparators
  // ----------------------------------------
  // last count of a P period; a P value of zero wraps this to 3FF, so
  // overflow clearing on P only arises with every P bit zero
  wire logic [9:0] p_end = {period_value, 7'h00} - 10'h001;
  wire logic [10:0] p_span = (period_value == CPT_PER_RESET) ?
                             CPT_FULL_SPAN : {1'b0, period_value, 7'h00};

  wire logic eq_a    = (count == compare_a_value);
  wire logic eq_p    = (count == p_end);
  wire logic a_zero  = (compare_a_value == CPT_CMPA_RESET);

  // clear-select only matters outside PWM
  wire logic clr_on_a = mode_pwm ? ctrl1.period_duty_swap : ctrl1.clear_select;

  // A value zero with clear-on-A leaves the counter to wrap at 3FF
  wire logic a_match = mode_pwm ? eq_a :
                       (eq_a & ~(ctrl1.clear_select & a_zero));
  wire logic p_match = mode_pwm ? eq_p :
                       (eq_p & ~ctrl1.clear_select);

  wire logic clear_now = clr_on_a ? (eq_a & ~a_zero) : eq_p;

  wire logic set_a = timer_run & a_match;
  wire logic set_p = timer_run & p_match;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  logic [9:0] next_count;
  always_comb begin
    if (!timer_run) begin
      next_count = CPT_COUNT_RESET;
    end else if (clear_now) begin
      next_count = CPT_COUNT_RESET;
    end else begin
      next_count = count + 10'h001;
    end
  end

  // ----------------------------------------
  // compare-mode pin level
  // ----------------------------------------
  logic next_pin_level;
  always_comb begin
    next_pin_level = pin_level;
    if (run_rise) begin
      next_pin_level = ctrl1.initial_output;
    end else if (mode_cmp && set_a) begin
      case (ctrl1.action)
        CPT_ACT_LOW:    next_pin_level = 1'b0;
        CPT_ACT_HIGH:   next_pin_level = 1'b1;
        CPT_ACT_TOGGLE: next_pin_level = ~pin_level;
        default:        next_pin_level = pin_level;
      endcase
    end
  end

  // ----------------------------------------
  // PWM waveform
  // ----------------------------------------
  // with swap 0 the count never reaches an A value at or above the
  // period, so the duty is full there without a special case
  wire logic duty_on = ctrl1.period_duty_swap ?
                       ({1'b0, count} < p_span) :
                       (count < compare_a_value);
  wire logic wave    = ctrl1.initial_output ? duty_on : ~duty_on;
  wire logic pwm_lvl = (ctrl1.action == CPT_ACT_NONE) ? 1'b0 :
                       (ctrl1.action == CPT_ACT_LOW)  ? 1'b1 :
                       (timer_run ? wave : pin_level);

  wire logic raw_pin      = mode_pwm ? pwm_lvl : next_pin_level;
  wire logic next_pin_out = pin_used ? (raw_pin ^ ctrl1.output_polarity) : 1'b0;

  // ----------------------------------------
  // flags: a new match outranks a software clear in the same cycle
  // ----------------------------------------
  wire logic clr_a = wr_status & PWDATA_IN[CPT_ST_FLAG_A];
  wire logic clr_p = wr_status & PWDATA_IN[CPT_ST_FLAG_P];
  wire logic next_flag_a = set_a | (compare_a_flag & ~clr_a);
  wire logic next_flag_p = set_p | (compare_p_flag & ~clr_p);

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  wire logic [9:0] next_cmpa = wr_cma_lo ? {compare_a_value[9:8], PWDATA_IN[7:0]} :
                               wr_cma_hi ? {PWDATA_IN[1:0], compare_a_value[7:0]} :
                               compare_a_value;
  wire logic       next_run  = wr_ctrl0 ? PWDATA_IN[CPT_C0_RUN_BIT] : timer_run;
  wire logic [2:0] next_per  = wr_ctrl0 ? PWDATA_IN[CPT_C0_PER_LSB +: CPT_PER_W] :
                               period_value;
  wire cpt_ctrl1_t next_ctrl1 = wr_ctrl1 ? cpt_ctrl1_t'(PWDATA_IN[7:0]) : ctrl1;

  // ----------------------------------------
  // APB answer: one wait-free access phase, data registered in setup
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PREADY_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= setup_cyc;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PSLVERR_OUT <= 1'b0;
    end else begin
      PSLVERR_OUT <= setup_cyc & ~mapped;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else begin
      PRDATA_OUT <= (setup_cyc & ~PWRITE_IN) ? read_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      compare_a_value <= CPT_CMPA_RESET;
    end else begin
      compare_a_value <= next_cmpa;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      timer_run <= 1'b0;
    end else begin
      timer_run <= next_run;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      period_value <= CPT_PER_RESET;
    end else begin
      period_value <= next_per;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ctrl1 <= cpt_ctrl1_t'(CPT_CTRL1_RESET);
    end else begin
      ctrl1 <= next_ctrl1;
    end
  end

  // ----------------------------------------
  // timer core
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      count <= CPT_COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      run_prev <= 1'b0;
    end else begin
      run_prev <= timer_run;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pin_level <= 1'b0;
    end else begin
      pin_level <= next_pin_level;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      compare_a_flag <= 1'b0;
    end else begin
      compare_a_flag <= next_flag_a;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      compare_p_flag <= 1'b0;
    end else begin
      compare_p_flag <= next_flag_p;
    end
  end

  // ----------------------------------------
  // pin and flag outputs
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      TIMER_PIN_OUT <= 1'b0;
    end else begin
      TIMER_PIN_OUT <= next_pin_out;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      TIMER_PIN_OE_OUT <= 1'b0;
    end else begin
      TIMER_PIN_OE_OUT <= pin_used;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      FLAG_A_OUT <= 1'b0;
    end else begin
      FLAG_A_OUT <= next_flag_a;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      FLAG_P_OUT <= 1'b0;
    end else begin
      FLAG_P_OUT <= next_flag_p;
    end
  end

endmodule : cpt_timer

`default_nettype wire

// file: test/cpt_timer_checker.sv
// port-level assertion checker for the compact timer
`timescale 1ns/1ps
`default_nettype none
module cpt_timer_checker
  import cpt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              SYS_CLK_IN,
  input wire logic              RESET_N_IN,
  input wire logic              PSEL_IN,
  input wire logic              PENABLE_IN,
  input wire logic              PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0]       PWDATA_IN,
  input wire logic [31:0]       PRDATA_OUT,
  input wire logic              PREADY_OUT,
  input wire logic              PSLVERR_OUT,
  input wire logic              TIMER_PIN_OUT,
  input wire logic              TIMER_PIN_OE_OUT,
  input wire logic              FLAG_A_OUT,
  input wire logic              FLAG_P_OUT
);
  // ----------------------------------------
  // shadow of control writes, seen from the bus
  // ----------------------------------------
  logic [7:0] ctl_sh;
  logic       run_sh;
  wire        wr_done = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ctl_sh <= 8'h00;
      run_sh <= 1'b0;
    end else begin
      if (wr_done && PADDR_IN == CPT_OFS_CONTROL_1) ctl_sh <= PWDATA_IN[7:0];
      if (wr_done && PADDR_IN == CPT_OFS_CONTROL_0) run_sh <= PWDATA_IN[0];
    end
  end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // ----------------------------------------
  // assertions; pin checks wait for the control register to settle
  // ----------------------------------------
  ready_after_setup_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("ready not a single cycle after setup");
  error_decode_a: assert property (PREADY_OUT |-> PSLVERR_OUT ==
    (PADDR_IN > CPT_OFS_STATUS || PADDR_IN[1:0] != 2'h0)) else $error("error response wrong");
  idle_data_zero_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
    else $error("read data outside access");
  byte_width_a: assert property (PREADY_OUT && !PWRITE_IN |-> PRDATA_OUT[31:8] == 24'h0)
    else $error("read data wider than a byte");
  high_byte_zero_a: assert property (PREADY_OUT && !PWRITE_IN && (PADDR_IN == CPT_OFS_COUNT_HIGH
    || PADDR_IN == CPT_OFS_CMPA_HIGH) |-> PRDATA_OUT[31:2] == 30'h0) else $error("high bits set");
  idle_count_zero_a: assert property (!run_sh && !$past(run_sh, 2) && !$past(run_sh, 3)
    && PREADY_OUT && !PWRITE_IN && PADDR_IN == CPT_OFS_COUNT_LOW |-> PRDATA_OUT == 32'h0)
    else $error("counter moved while stopped");
  pin_idle_timer_a: assert property (ctl_sh[6] && $past(ctl_sh, 2) == ctl_sh
    |-> !TIMER_PIN_OE_OUT && !TIMER_PIN_OUT) else $error("pin driven in timer mode");
  pin_enable_a: assert property (!ctl_sh[6] && $past(ctl_sh, 2) == ctl_sh
    && $past(RESET_N_IN) |-> TIMER_PIN_OE_OUT) else $error("pin not enabled in output mode");
  pwm_forced_a: assert property (ctl_sh[7:6] == 2'h2 && ctl_sh[5:4] == 2'h0
    && $past(ctl_sh, 2) == ctl_sh |-> TIMER_PIN_OUT == ctl_sh[2]) else $error("forced level wrong");
  no_p_flag_a: assert property (ctl_sh[0] && ctl_sh[7:6] != 2'h2 && $past(ctl_sh, 3) == ctl_sh
    |-> !$rose(FLAG_P_OUT)) else $error("p flag raised with clear on a");
endmodule : cpt_timer_checker
`default_nettype wire

// file: test/cpt_timer_bench.sv
// self-checking testbench of the compact timer
`timescale 1ns/1ps
`default_nettype none
module cpt_timer_bench import cpt_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, pin, pin_oe, flag_a, flag_p, err;
  logic [31:0] rdata;
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;
  // ----------------------------------------
  // stimulus tables: control byte, compare a, expected high samples
  // ----------------------------------------
  logic [7:0]  cmp_ctl [5] = '{8'h31, 8'h09, 8'h19, 8'h1D, 8'h21};
  int          cmp_exp [5] = '{30, 60, 0, 60, 60};
  logic [7:0]  pwm_ctl [6] = '{8'hA9, 8'hA8, 8'hAC, 8'h88, 8'h98, 8'hAB};
  logic [7:0]  pwm_a   [6] = '{8'h20, 8'hC8, 8'hC8, 8'h20, 8'h20, 8'hFF};
  int          pwm_exp [6] = '{128, 512, 0, 0, 512, 256};
  logic [7:0]  offs    [7] = '{CPT_OFS_COUNT_LOW, CPT_OFS_COUNT_HIGH, CPT_OFS_CMPA_LOW,
    CPT_OFS_CMPA_HIGH, CPT_OFS_CONTROL_0, CPT_OFS_CONTROL_1, CPT_OFS_STATUS};
  always #20 sys_clk = ~sys_clk;
  cpt_timer cpt_timer_i (.SYS_CLK_IN(sys_clk), .RESET_N_IN(reset_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TIMER_PIN_OUT(pin),
    .TIMER_PIN_OE_OUT(pin_oe), .FLAG_A_OUT(flag_a), .FLAG_P_OUT(flag_p));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb_xfer
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : check_data
  task automatic check_cnt(input int got, input int exp);
    checks++;
    if (got != exp) begin
      mismatches++;
      $display("Error at %0t: pin high %0d cycles expected %0d", $time, got, exp);
    end
  endtask : check_cnt
  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    apb_xfer(1'b1, addr, wd);
  endtask : wr
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    apb_xfer(1'b0, addr, 32'h0);
    check_data(rdata, exp);
  endtask : rd
  // whole periods in the window make the count independent of phase
  task automatic high_cycles(input int n, input int exp);
    int h;
    h = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if (pin === 1'b1) h++;
    end
    check_cnt(h, exp);
  endtask : high_cycles
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    foreach (offs[i]) rd(offs[i], 32'h0);
    apb_xfer(1'b0, 8'h1C, 32'h0);
    check_data({31'h0, err}, 32'h1);
    wr(CPT_OFS_CMPA_HIGH, 32'hFFFFFFFF);
    rd(CPT_OFS_CMPA_HIGH, 32'h3);
    wr(CPT_OFS_COUNT_LOW, 32'hFF);
    rd(CPT_OFS_COUNT_LOW, 32'h0);
    wr(CPT_OFS_CMPA_HIGH, 32'h0);
    wr(CPT_OFS_CMPA_LOW, 32'h105);
    rd(CPT_OFS_CMPA_LOW, 32'h5);
    $display("registers done");
    foreach (cmp_ctl[i]) begin
      wr(CPT_OFS_CONTROL_0, 32'h0);
      wr(CPT_OFS_CONTROL_1, {24'h0, cmp_ctl[i]});
      wr(CPT_OFS_CONTROL_0, 32'h1);
      repeat (10) @(posedge sys_clk);
      high_cycles(60, cmp_exp[i]);
    end
    rd(CPT_OFS_STATUS, 32'h1);
    check_data({30'h0, flag_p, flag_a}, 32'h1);
    wr(CPT_OFS_CONTROL_0, 32'h0);
    wr(CPT_OFS_STATUS, 32'h3);
    rd(CPT_OFS_STATUS, 32'h0);
    wr(CPT_OFS_CMPA_LOW, 32'h0);
    wr(CPT_OFS_CONTROL_1, 32'h01);
    wr(CPT_OFS_CONTROL_0, 32'h1);
    repeat (1100) @(posedge sys_clk);
    rd(CPT_OFS_STATUS, 32'h0);
    check_data({30'h0, flag_p, flag_a}, 32'h0);
    $display("compare clear on a done");
    wr(CPT_OFS_CMPA_LOW, 32'h5);
    wr(CPT_OFS_CONTROL_1, 32'h20);
    wr(CPT_OFS_CONTROL_0, 32'h0);
    wr(CPT_OFS_STATUS, 32'h3);
    wr(CPT_OFS_CONTROL_0, 32'h11);
    repeat (300) @(posedge sys_clk);
    rd(CPT_OFS_STATUS, 32'h3);
    check_data({30'h0, flag_p, flag_a}, 32'h3);
    rd(CPT_OFS_COUNT_HIGH, 32'h0);
    high_cycles(10, 10);
    wr(CPT_OFS_CONTROL_1, 32'hC4);
    wr(CPT_OFS_STATUS, 32'h3);
    repeat (300) @(posedge sys_clk);
    check_data({30'h0, pin_oe, pin}, 32'h0);
    rd(CPT_OFS_STATUS, 32'h3);
    wr(CPT_OFS_CONTROL_1, 32'h40);
    repeat (3) @(posedge sys_clk);
    check_data({30'h0, pin_oe, pin}, 32'h0);
    $display("compare clear on p done");
    foreach (pwm_ctl[i]) begin
      wr(CPT_OFS_CONTROL_0, 32'h0);
      wr(CPT_OFS_CMPA_LOW, {24'h0, pwm_a[i]});
      wr(CPT_OFS_CONTROL_1, {24'h0, pwm_ctl[i]});
      wr(CPT_OFS_CONTROL_0, 32'h11);
      repeat (20) @(posedge sys_clk);
      high_cycles(512, pwm_exp[i]);
    end
    wr(CPT_OFS_CMPA_LOW, 32'h20);
    wr(CPT_OFS_CONTROL_1, 32'h88);
    wr(CPT_OFS_STATUS, 32'h3);
    repeat (300) @(posedge sys_clk);
    rd(CPT_OFS_STATUS, 32'h3);
    $display("pwm done");
    wr(CPT_OFS_CONTROL_1, 32'h00);
    wr(CPT_OFS_CONTROL_0, 32'h1);
    wr(CPT_OFS_STATUS, 32'h3);
    repeat (1100) @(posedge sys_clk);
    rd(CPT_OFS_STATUS, 32'h3);
    wr(CPT_OFS_CONTROL_0, 32'h0);
    repeat (3) @(posedge sys_clk);
    rd(CPT_OFS_COUNT_LOW, 32'h0);
    $display("overflow done");
    finish_test();
  end
endmodule : cpt_timer_bench
bind cpt_timer cpt_timer_checker #(.ADDR_W(ADDR_W)) cpt_timer_checker_i (
  .SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .TIMER_PIN_OUT(TIMER_PIN_OUT),
  .TIMER_PIN_OE_OUT(TIMER_PIN_OE_OUT), .FLAG_A_OUT(FLAG_A_OUT), .FLAG_P_OUT(FLAG_P_OUT));
`default_nettype wire
